// File: rtl/pixel_mix_pkg.sv
package pixel_mix_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_PLANE_READ_MASK = 16'haee8;
  localparam logic [15:0] OFS_COLOUR_COMPARE = 16'hb2e8;
  localparam logic [15:0] OFS_BACKGROUND_MIX = 16'hb6e8;
  localparam logic [15:0] OFS_FOREGROUND_MIX = 16'hbae8;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int RASTER_OP_MSB = 4;
  localparam int SOURCE_LSB = 5;
  localparam int SOURCE_MSB = 6;
  localparam logic [15:0] MIX_FIELD_MASK = 16'h007f;
  localparam logic [15:0] MIX_RESET = 16'h0000;
  localparam logic [7:0] SEGMENT_RESET = 8'h00;
  localparam logic [7:0] COMPONENT_MAX = 8'hff;
  localparam logic [7:0] COMPONENT_MIN = 8'h00;

  // ----------------------------------------------------------------
  // pixel depth, source and compare encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] DEPTH_4BPP = 2'h0;
  localparam logic [1:0] DEPTH_8BPP = 2'h1;
  localparam logic [1:0] DEPTH_16BPP = 2'h2;
  localparam logic [1:0] DEPTH_32BPP = 2'h3;
  localparam logic [1:0] SRC_BACKGROUND = 2'h0;
  localparam logic [1:0] SRC_FOREGROUND = 2'h1;
  localparam logic [1:0] SRC_HOST = 2'h2;
  localparam logic [1:0] SRC_BITMAP = 2'h3;
  localparam logic [2:0] CMP_FALSE = 3'h0;
  localparam logic [2:0] CMP_TRUE = 3'h1;
  localparam logic [2:0] CMP_GE = 3'h2;
  localparam logic [2:0] CMP_LT = 3'h3;
  localparam logic [2:0] CMP_NE = 3'h4;
  localparam logic [2:0] CMP_EQ = 3'h5;
  localparam logic [2:0] CMP_LE = 3'h6;
  localparam logic [2:0] CMP_GT = 3'h7;
  localparam logic [4:0] MIX_SUM_SAT = 5'h1b;
endpackage

// File: rtl/pixel_raster_mix_unit.sv
`timescale 1ns/10ps
module pixel_raster_mix_unit
  import pixel_mix_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] ioAddr,
  input wire logic [15:0] ioWrData,
  input wire logic [1:0] ioByteEn,
  input wire logic ioWr,
  input wire logic ioRd,
  output logic [15:0] ioRdData,
  input wire logic extControl1Write,
  input wire logic commandActive,
  input wire logic softReset,
  input wire logic [1:0] pixelDepth,
  input wire logic [2:0] compareOperator,
  input wire logic acrossPlane,
  input wire logic pixelValid,
  input wire logic [3:0] mixChoice,
  input wire logic [31:0] bgColour,
  input wire logic [31:0] fgColour,
  input wire logic [31:0] hostData,
  input wire logic [31:0] bitmapData,
  input wire logic [31:0] dstData,
  output logic [31:0] mixResult,
  output logic [3:0] pixelKeep,
  output logic resultValid
);

  // ----------------------------------------------------------------
  // mix and compare functions on one 8-bit lane
  // ----------------------------------------------------------------
  function automatic logic [7:0] mix8(input logic [4:0] op,
                                      input logic [7:0] s,
                                      input logic [7:0] d);
    logic [8:0] sum;
    logic [8:0] ds;
    logic [8:0] sd;
    logic [7:0] r;
    sum = {1'b0, s} + {1'b0, d};
    ds = {1'b0, d} - {1'b0, s};
    sd = {1'b0, s} - {1'b0, d};
    r = d;
    case (op)
      5'h00: r = ~d;
      5'h01: r = 8'h00;
      5'h02: r = 8'hff;
      5'h03: r = d;
      5'h04: r = ~s;
      5'h05: r = s ^ d;
      5'h06: r = ~(s ^ d);
      5'h07: r = s;
      5'h08: r = ~(s & d);
      5'h09: r = ~s | d;
      5'h0a: r = s | ~d;
      5'h0b: r = s | d;
      5'h0c: r = s & d;
      5'h0d: r = s & ~d;
      5'h0e: r = ~s & d;
      5'h0f: r = ~(s | d);
      5'h10: r = (s < d) ? s : d;
      5'h11: r = ds[7:0];
      5'h12: r = sd[7:0];
      5'h13: r = sum[7:0];
      5'h14: r = (s > d) ? s : d;
      // halved forms keep the ninth bit so the shift sees the true value
      5'h15: r = ds[8:1];
      5'h16: r = sd[8:1];
      5'h17: r = sum[8:1];
      5'h18, 5'h19: r = ds[8] ? COMPONENT_MIN : ds[7:0];
      5'h1a: r = sd[8] ? COMPONENT_MIN : sd[7:0];
      5'h1b: r = sum[8] ? COMPONENT_MAX : sum[7:0];
      5'h1c, 5'h1d: r = ds[8] ? COMPONENT_MIN : {1'b0, ds[7:1]};
      5'h1e: r = sd[8] ? COMPONENT_MIN : {1'b0, sd[7:1]};
      5'h1f: r = sum[8:1];
      default: r = d;
    endcase
    return r;
  endfunction

  function automatic logic cmp8(input logic [2:0] op,
                                input logic [7:0] d,
                                input logic [7:0] c);
    logic hit;
    hit = 1'b0;
    unique case (op)
      CMP_FALSE: hit = 1'b0;
      CMP_TRUE: hit = 1'b1;
      CMP_GE: hit = d >= c;
      CMP_LT: hit = d < c;
      CMP_NE: hit = d != c;
      CMP_EQ: hit = d == c;
      CMP_LE: hit = d <= c;
      CMP_GT: hit = d > c;
    endcase
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic [7:0] maskSeg [4];
  logic [7:0] cmpSeg [4];
  logic [1:0] maskCnt;
  logic [1:0] cmpCnt;
  logic [15:0] backgroundMix;
  logic [15:0] foregroundMix;
  logic [15:0] next_rdData;

  wire hitMask = ioAddr == OFS_PLANE_READ_MASK;
  wire hitCmp = ioAddr == OFS_COLOUR_COMPARE;
  wire hitBg = ioAddr == OFS_BACKGROUND_MIX;
  wire hitFg = ioAddr == OFS_FOREGROUND_MIX;
  // only the low byte carries segment data; the high byte is reserved
  wire maskLoad = ioWr && hitMask && ioByteEn[0];
  wire cmpLoad = ioWr && hitCmp && ioByteEn[0];
  wire segClear = extControl1Write || commandActive || softReset;
  wire highDepth = pixelDepth[1];
  wire [1:0] segWrap = (pixelDepth == DEPTH_32BPP) ? 2'h3 :
                       (pixelDepth == DEPTH_16BPP) ? 2'h1 : 2'h0;
  // each register steps only its own counter
  wire [1:0] next_maskCnt = segClear ? 2'h0 :
                            maskLoad ? ((maskCnt + 2'h1) & segWrap) :
                            maskCnt;
  wire [1:0] next_cmpCnt = segClear ? 2'h0 :
                           cmpLoad ? ((cmpCnt + 2'h1) & segWrap) :
                           cmpCnt;

  assign next_rdData = hitMask ? {8'h00, maskSeg[0]} :
                       hitCmp ? {8'h00, cmpSeg[0]} :
                       hitBg ? (backgroundMix & MIX_FIELD_MASK) :
                       hitFg ? (foregroundMix & MIX_FIELD_MASK) : 16'h0000;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      maskCnt <= 2'h0;
      cmpCnt <= 2'h0;
    end else begin
      maskCnt <= next_maskCnt;
      cmpCnt <= next_cmpCnt;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      backgroundMix <= MIX_RESET;
      foregroundMix <= MIX_RESET;
    end else if (ioWr && (hitBg || hitFg)) begin
      if (hitBg && ioByteEn[0]) begin
        backgroundMix[7:0] <= ioWrData[7:0];
      end
      if (hitBg && ioByteEn[1]) begin
        backgroundMix[15:8] <= ioWrData[15:8];
      end
      if (hitFg && ioByteEn[0]) begin
        foregroundMix[7:0] <= ioWrData[7:0];
      end
      if (hitFg && ioByteEn[1]) begin
        foregroundMix[15:8] <= ioWrData[15:8];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ioRdData <= 16'h0000;
    end else if (ioRd) begin
      ioRdData <= next_rdData;
    end
  end

  // ----------------------------------------------------------------
  // per-lane datapath, one 8-bit lane per nugget pixel segment
  // ----------------------------------------------------------------
  logic [7:0] laneMix [4];
  logic [4:0] laneOp [4];
  logic laneEq [4];
  logic laneHit [4];
  logic [3:0] next_keep;
  logic [31:0] next_result;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gLane
      localparam int PAIR = g % 2;
      // narrower depths replicate their low segments across the nugget
      wire [1:0] segIdx = (pixelDepth == DEPTH_32BPP) ? 2'(g) :
                          (pixelDepth == DEPTH_16BPP) ? 2'(PAIR) : 2'h0;
      wire [7:0] dstByte = dstData[8*g +: 8];
      wire [7:0] cmpByte = cmpSeg[segIdx];
      wire [7:0] maskByte = maskSeg[segIdx];
      wire useFg = mixChoice[g];
      wire [15:0] mixReg = useFg ? foregroundMix : backgroundMix;
      wire [1:0] srcSel = mixReg[SOURCE_MSB:SOURCE_LSB];
      wire [7:0] hostByte = acrossPlane ? hostData[8*g +: 8] :
                            hostData[8*segIdx +: 8];
      wire [7:0] srcByte = (srcSel == SRC_BACKGROUND) ? bgColour[8*g +: 8] :
                           (srcSel == SRC_FOREGROUND) ? fgColour[8*g +: 8] :
                           (srcSel == SRC_HOST) ? hostByte :
                           bitmapData[8*g +: 8];
      // masked planes read as zero into the mix
      wire [7:0] srcRead = srcByte & ~maskByte;
      wire [7:0] dstRead = dstByte & ~maskByte;
      wire arithBlocked = highDepth && laneOp[g][RASTER_OP_MSB];
      assign laneOp[g] = mixReg[RASTER_OP_MSB:0];
      // high colour depths have no arithmetic path; leave dst as is
      assign laneMix[g] = arithBlocked ? dstByte :
                          mix8(laneOp[g], srcRead, dstRead);
      assign laneEq[g] = dstByte == cmpByte;
      assign laneHit[g] = cmp8(compareOperator, dstByte, cmpByte);
      // wide pixels span lanes, so equality must hold on the whole pixel
      assign next_keep[g] =
        (!highDepth || compareOperator != CMP_EQ) ? laneHit[g] :
        (pixelDepth == DEPTH_16BPP) ? (laneEq[g] && laneEq[g ^ 1]) :
        (laneEq[0] && laneEq[1] && laneEq[2] && laneEq[3]);
      assign next_result[8*g +: 8] = next_keep[g] ? dstByte :
                                     laneMix[g];
    end
  endgenerate

  generate
    for (g = 0; g < 4; g++) begin : gSeg
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          maskSeg[g] <= SEGMENT_RESET;
          cmpSeg[g] <= SEGMENT_RESET;
        end else begin
          if (maskLoad && maskCnt == 2'(g)) begin
            maskSeg[g] <= ioWrData[7:0];
          end
          if (cmpLoad && cmpCnt == 2'(g)) begin
            cmpSeg[g] <= ioWrData[7:0];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mixResult <= 32'h00000000;
      pixelKeep <= 4'h0;
      resultValid <= 1'b0;
    end else begin
      resultValid <= pixelValid;
      if (pixelValid) begin
        mixResult <= next_result;
        pixelKeep <= next_keep;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_cmp_load_clean;
    cmpLoad && !segClear && pixelDepth == DEPTH_16BPP;
  endsequence

  sequence s_cmp_pair_loaded;
    s_cmp_load_clean ##1 (!cmpLoad && !segClear) ##1 s_cmp_load_clean;
  endsequence

  property p_mask_step32;
    @(posedge mclk) disable iff (rst)
      (maskLoad && !segClear && pixelDepth == DEPTH_32BPP) |=>
        maskCnt == 2'($past(maskCnt) + 2'h1);
  endproperty
  a_mask_step32: assert property (p_mask_step32)
    else $error("read mask counter did not step modulo four");

  property p_seg_clear;
    @(posedge mclk) disable iff (rst)
      segClear |=> (maskCnt == 2'h0 && cmpCnt == 2'h0);
  endproperty
  a_seg_clear: assert property (p_seg_clear)
    else $error("segment counter not cleared");

  property p_mask_readback;
    @(posedge mclk) disable iff (rst)
      (ioRd && hitMask) |=> ioRdData == {8'h00, $past(maskSeg[0])};
  endproperty
  a_mask_readback: assert property (p_mask_readback)
    else $error("read mask readback not first segment");

  property p_counter_independent;
    @(posedge mclk) disable iff (rst)
      (maskLoad && !cmpLoad && !segClear) |=> $stable(cmpCnt);
  endproperty
  a_counter_independent: assert property (p_counter_independent)
    else $error("mask load moved compare counter");

  property p_cmp_wrap16;
    @(posedge mclk) disable iff (rst)
      s_cmp_pair_loaded |=> cmpCnt == $past(cmpCnt, 3);
  endproperty
  a_cmp_wrap16: assert property (p_cmp_wrap16)
    else $error("compare counter not modulo two");

  property p_keep_dst;
    @(posedge mclk) disable iff (rst)
      (pixelValid && next_keep[0]) |=>
        (pixelKeep[0] && mixResult[7:0] == $past(dstData[7:0]));
  endproperty
  a_keep_dst: assert property (p_keep_dst)
    else $error("kept pixel was modified");

  property p_eq_8bpp;
    @(posedge mclk) disable iff (rst)
      (pixelValid && pixelDepth == DEPTH_8BPP && compareOperator == CMP_EQ &&
       dstData[15:8] == cmpSeg[0]) |=> pixelKeep[1];
  endproperty
  a_eq_8bpp: assert property (p_eq_8bpp)
    else $error("byte compare missed equal pixel");

  property p_no_arith_high;
    @(posedge mclk) disable iff (rst)
      (pixelValid && highDepth && laneOp[0][RASTER_OP_MSB]) |=>
        mixResult[7:0] == $past(dstData[7:0]);
  endproperty
  a_no_arith_high: assert property (p_no_arith_high)
    else $error("arithmetic mix applied in high colour depth");

  property p_sum_saturates;
    @(posedge mclk) disable iff (rst)
      (pixelValid && !highDepth && laneOp[0] == MIX_SUM_SAT &&
       !next_keep[0] && gLane[0].srcRead >= ~gLane[0].dstRead) |=>
        mixResult[7:0] == COMPONENT_MAX;
  endproperty
  a_sum_saturates: assert property (p_sum_saturates)
    else $error("saturating sum did not clamp");

endmodule

// File: verification/host_io_model.sv
`timescale 1ns/10ps
// ----
// host side of the byte/word i/o register port
// ----
// the host never starts fills or line draws
module host_io_model (
  input wire logic mclk,
  input wire logic [15:0] ioRdData,
  output logic [15:0] ioAddr,
  output logic [15:0] ioWrData,
  output logic [1:0] ioByteEn,
  output logic ioWr,
  output logic ioRd
);
  initial begin
    ioAddr = 16'h0000;
    ioWrData = 16'h0000;
    ioByteEn = 2'h0;
    ioWr = 1'b0;
    ioRd = 1'b0;
  end

  // released address and data lines show the inverse, so a held value cannot pass by luck
  task automatic wr(input logic [15:0] a, input logic [15:0] d,
    input logic [1:0] be);
    @(posedge mclk);
    ioAddr <= a;
    ioWrData <= d;
    ioByteEn <= be;
    ioWr <= 1'b1;
    @(posedge mclk);
    ioWr <= 1'b0;
    ioAddr <= ~a;
    ioWrData <= ~d;
    ioByteEn <= 2'h0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge mclk);
    ioAddr <= a;
    ioRd <= 1'b1;
    @(posedge mclk);
    ioRd <= 1'b0;
    ioAddr <= ~a;
    #1;
    d = ioRdData;
  endtask
endmodule

// File: verification/pixel_raster_mix_unit_bench.sv
`timescale 1ns/10ps
module pixel_raster_mix_unit_bench;
  import pixel_mix_pkg::*;
  logic mclk, rst, ioWr, ioRd, acrossPlane, pixelValid, resultValid;
  logic [15:0] ioAddr, ioWrData, ioRdData, rdv;
  logic [1:0] ioByteEn, pixelDepth;
  logic [2:0] compareOperator, clrPulse;
  logic [3:0] mixChoice, pixelKeep, k;
  logic [31:0] bgColour, fgColour, hostData, bitmapData, dstData;
  logic [31:0] mixResult, e;
  logic [4:0] c5;
  logic [15:0] ofs [4];
  int n_fail, n_tests;
  wire extControl1Write = clrPulse[0];
  wire commandActive = clrPulse[1];
  wire softReset = clrPulse[2];

  host_io_model u_host (.mclk, .ioRdData, .ioAddr, .ioWrData, .ioByteEn,
    .ioWr, .ioRd);
  pixel_raster_mix_unit u_dut (.mclk, .rst, .ioAddr, .ioWrData, .ioByteEn,
    .ioWr, .ioRd, .ioRdData, .extControl1Write, .commandActive, .softReset,
    .pixelDepth, .compareOperator, .acrossPlane, .pixelValid, .mixChoice,
    .bgColour, .fgColour, .hostData, .bitmapData, .dstData, .mixResult,
    .pixelKeep, .resultValid);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----
  // expected values and helpers
  // ----
  function automatic logic [7:0] mixf(input logic [4:0] c,
    input logic [7:0] s, input logic [7:0] d);
    logic [8:0] ds, sd, sm;
    ds = {1'b0, d} - {1'b0, s};
    sd = {1'b0, s} - {1'b0, d};
    sm = {1'b0, s} + {1'b0, d};
    case (c)
      5'h00: return ~d;
      5'h02: return 8'hff;
      5'h03: return d;
      5'h04: return ~s;
      5'h05: return s ^ d;
      5'h06: return ~(s ^ d);
      5'h07: return s;
      5'h08: return ~(s & d);
      5'h09: return ~s | d;
      5'h0a: return s | ~d;
      5'h0b: return s | d;
      5'h0c: return s & d;
      5'h0d: return s & ~d;
      5'h0e: return ~s & d;
      5'h0f: return ~(s | d);
      5'h10: return (s < d) ? s : d;
      5'h11: return ds[7:0];
      5'h12: return sd[7:0];
      5'h13: return sm[7:0];
      5'h14: return (s > d) ? s : d;
      5'h15: return ds[8:1];
      5'h16: return sd[8:1];
      5'h17, 5'h1f: return sm[8:1];
      5'h18, 5'h19: return ds[8] ? 8'h00 : ds[7:0];
      5'h1a: return sd[8] ? 8'h00 : sd[7:0];
      5'h1b: return sm[8] ? 8'hff : sm[7:0];
      5'h1c, 5'h1d: return ds[8] ? 8'h00 : ds[8:1];
      5'h1e: return sd[8] ? 8'h00 : sd[8:1];
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic cmpf(input int op, input logic [7:0] d);
    logic [7:0] c;
    c = 8'h40;
    case (op)
      0: return 1'b0;
      1: return 1'b1;
      2: return d >= c;
      3: return d < c;
      4: return d != c;
      5: return d == c;
      6: return d <= c;
      default: return d > c;
    endcase
  endfunction

  function automatic logic [7:0] srcb(input int sl, input int g);
    case (sl)
      0: return bgColour[8*g+:8];
      1: return fgColour[8*g+:8];
      2: return hostData[8*g+:8];
      default: return bitmapData[8*g+:8];
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [15:0] x);
    u_host.rd(a, rdv);
    chk({16'h0000, rdv}, {16'h0000, x});
  endtask

  task automatic clr(input int i);
    @(posedge mclk);
    clrPulse[i] <= 1'b1;
    @(posedge mclk);
    clrPulse <= 3'h0;
  endtask

  task automatic mode(input logic [1:0] dp, input logic [2:0] op,
    input logic ap);
    @(posedge mclk);
    pixelDepth <= dp;
    compareOperator <= op;
    acrossPlane <= ap;
  endtask

  task automatic setc(input logic [31:0] b, input logic [31:0] f,
    input logic [31:0] h, input logic [31:0] m);
    @(posedge mclk);
    bgColour <= b;
    fgColour <= f;
    hostData <= h;
    bitmapData <= m;
  endtask

  task automatic setmix(input logic [15:0] b, input logic [15:0] f);
    u_host.wr(OFS_BACKGROUND_MIX, b, 2'h3);
    u_host.wr(OFS_FOREGROUND_MIX, f, 2'h3);
  endtask

  task automatic px(input logic [31:0] d, input logic [3:0] ch,
    input logic [31:0] xr, input logic [3:0] xk);
    @(posedge mclk);
    dstData <= d;
    mixChoice <= ch;
    pixelValid <= 1'b1;
    @(posedge mclk);
    pixelValid <= 1'b0;
    #1;
    chk({31'h0, resultValid}, 32'h1);
    chk(mixResult, xr);
    chk({28'h0, pixelKeep}, {28'h0, xk});
    @(posedge mclk);
    #1;
    chk({31'h0, resultValid}, 32'h0);
  endtask

  // ----
  // watchdog and main sequence
  // ----
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    close_out();
  end

  initial begin
    ofs = '{OFS_PLANE_READ_MASK, OFS_COLOUR_COMPARE, OFS_BACKGROUND_MIX,
      OFS_FOREGROUND_MIX};
    rst = 1'b1;
    clrPulse = 3'h0;
    pixelDepth = DEPTH_32BPP;
    compareOperator = CMP_FALSE;
    acrossPlane = 1'b1;
    pixelValid = 1'b0;
    mixChoice = 4'h0;
    {bgColour, fgColour, hostData, bitmapData, dstData} = '0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rdchk(ofs[i], 16'h0000);
    setmix(16'hffff, 16'hffff);
    u_host.wr(16'h1234, 16'h5555, 2'h3);
    rdchk(OFS_BACKGROUND_MIX, MIX_FIELD_MASK);
    rdchk(OFS_FOREGROUND_MIX, MIX_FIELD_MASK);
    rdchk(16'h1234, 16'h0000);
    clr(0);
    u_host.wr(OFS_PLANE_READ_MASK, 16'hee11, 2'h1);
    u_host.wr(OFS_COLOUR_COMPARE, 16'h0077, 2'h1);
    for (int i = 2; i < 5; i++)
      u_host.wr(OFS_PLANE_READ_MASK, 16'(i * 17), 2'h1);
    rdchk(OFS_PLANE_READ_MASK, 16'h0011);
    rdchk(OFS_COLOUR_COMPARE, 16'h0077);
    setmix(16'h0007, 16'h0007);
    setc(32'hffffffff, 32'h0, 32'h0, 32'h0);
    px(32'h0, 4'h0, 32'hbbccddee, 4'h0);
    for (int i = 0; i < 3; i++) begin
      clr(0);
      u_host.wr(OFS_PLANE_READ_MASK, 16'h005a, 2'h1);
      clr(i);
      u_host.wr(OFS_PLANE_READ_MASK, 16'h003c, 2'h1);
      rdchk(OFS_PLANE_READ_MASK, 16'h003c);
    end
    clr(0);
    for (int i = 0; i < 4; i++) u_host.wr(OFS_PLANE_READ_MASK, 16'h0, 2'h1);
    // equality spans the whole pixel only in the wide modes
    mode(DEPTH_16BPP, CMP_EQ, 1'b1);
    clr(1);
    u_host.wr(OFS_COLOUR_COMPARE, 16'h0012, 2'h1);
    u_host.wr(OFS_COLOUR_COMPARE, 16'h0034, 2'h1);
    setc(32'h0, 32'h0, 32'h0, 32'h0);
    px(32'h34123499, 4'h0, 32'h34120000, 4'hc);
    setmix(16'h0013, 16'h0013);
    setc(32'h10101010, 32'h0, 32'h0, 32'h0);
    px(32'h01020304, 4'h0, 32'h01020304, 4'h0);
    mode(DEPTH_32BPP, CMP_EQ, 1'b1);
    clr(2);
    for (int i = 0; i < 4; i++)
      u_host.wr(OFS_COLOUR_COMPARE, 16'(8'ha1 + i * 17), 2'h1);
    setmix(16'h0007, 16'h0007);
    setc(32'h0, 32'h0, 32'h0, 32'h0);
    px(32'hd4c3b2a1, 4'h0, 32'hd4c3b2a1, 4'hf);
    px(32'hd4c3b2a0, 4'h0, 32'h0, 4'h0);
    mode(DEPTH_8BPP, CMP_FALSE, 1'b1);
    clr(0);
    u_host.wr(OFS_COLOUR_COMPARE, 16'h0040, 2'h1);
    setmix(16'h0002, 16'h0002);
    for (int op = 0; op < 8; op++) begin
      mode(DEPTH_8BPP, 3'(op), 1'b1);
      for (int g = 0; g < 4; g++) begin
        k[g] = cmpf(op, 8'(32'h3f414040 >> (8 * g)));
        e[8*g+:8] = k[g] ? 8'(32'h3f414040 >> (8 * g)) : 8'hff;
      end
      px(32'h3f414040, 4'h0, e, k);
    end
    mode(DEPTH_8BPP, CMP_FALSE, 1'b1);
    setc(32'h0, 32'h10f0c0b5, 32'h0, 32'h0);
    for (int c = 0; c < 32; c++) begin
      c5 = 5'(c);
      setmix({9'h0, 2'h1, c5}, {9'h0, 2'h1, ~c5});
      for (int g = 0; g < 4; g++)
        e[8*g+:8] = mixf(g[0] ? ~c5 : c5, fgColour[8*g+:8],
          8'(32'h300fc35a >> (8 * g)));
      px(32'h300fc35a, 4'ha, e, 4'h0);
    end
    setc(32'hb3b2b1b0, 32'hf3f2f1f0, 32'h93929190, 32'h33323130);
    for (int sl = 0; sl < 4; sl++) begin
      setmix({9'h0, 2'(sl), 5'h07}, {9'h0, 2'(3 - sl), 5'h07});
      for (int g = 0; g < 4; g++) e[8*g+:8] = srcb(g < 2 ? sl : 3 - sl, g);
      px(32'h0, 4'hc, e, 4'h0);
    end
    mode(DEPTH_4BPP, CMP_FALSE, 1'b0);
    setmix(16'h0047, 16'h0047);
    px(32'h0, 4'h0, 32'h90909090, 4'h0);
    close_out();
  end
endmodule
